/* verilog/reset_strap_config.v */
// strap capture at reset release plus the device configuration register
// assumes straps stable through reset and a single-cycle strobe register port
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "strap_cfg_regs.vh"
module reset_strap_config (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // strap pins
  input wire endian_strap,
  input wire [1:0] boot_select_straps,
  input wire narrow_lane_fix_strap,
  input wire clock_source_strap,
  // register port
  input wire [31:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  // latched configuration
  output reg little_endian_select,
  output reg [1:0] boot_mode,
  output reg host_boot,
  output reg [1:0] space_one_width,
  output reg big_endian_lane_fix,
  output reg clock_times_four,
  output reg clock_strap_reserved,
  output reg config_valid,
  output wire narrow_on_high_lane,
  output reg ext_mem_clk_source_sel
);
  // capture sequencer: armed through reset, loads once, then holds
  localparam CAP_ARMED = 2'h0;
  localparam CAP_HOLD = 2'h1;

  // synchronised strap levels
  wire [4:0] strap_sync;
  wire sync_endian;
  wire [1:0] sync_boot;
  wire sync_lane_fix;
  wire sync_clk;

  // capture control
  reg [1:0] cap_state_ff;
  reg [1:0] nxt_cap_state;
  reg load_straps;

  // next values of the latched configuration
  reg nxt_little_endian;
  reg [1:0] nxt_boot_mode;
  reg nxt_host_boot;
  reg [1:0] nxt_space_one_width;
  reg nxt_lane_fix;
  reg nxt_clock_times_four;
  reg nxt_clock_strap_reserved;
  reg nxt_config_valid;

  // configuration register and read path
  reg cfg_ff;
  reg nxt_cfg;
  reg [31:0] nxt_rdata;

  // chip-enable space one width from the boot code
  function [1:0] width_of;
    input [1:0] code;
    begin
      case (code)
        `BOOT_ROM8: width_of = `WIDTH_8;
        `BOOT_ROM16: width_of = `WIDTH_16;
        default: width_of = `WIDTH_32;
      endcase
    end
  endfunction

  // only code 00 boots through the host port or emulation
  function is_host_code;
    input [1:0] code;
    begin
      is_host_code = (code == `BOOT_HOST);
    end
  endfunction

  // one word address only; the rest of the block reads as zero
  function hits_config;
    input [31:0] a;
    begin
      hits_config = (a == `DEVICE_CONFIG_ADDR);
    end
  endfunction

  // reserved bits are not stored, so they always read back zero
  function [31:0] config_word;
    input sel;
    begin
      config_word = `DEVICE_CONFIG_RESET;
      config_word[`EXT_CLK_SEL_BIT] = sel;
    end
  endfunction

  // straps are pins, so two flops before any logic reads them;
  // never cleared, so the flops carry live pin levels at release
  strap_sync #(
    .W(5)
  ) u_sync (
    .mclk(mclk),
    .rst_n(1'h1),
    .async_in({clock_source_strap, narrow_lane_fix_strap, boot_select_straps, endian_strap}),
    .sync_out(strap_sync)
  );

  assign sync_endian = strap_sync[0];
  assign sync_boot = strap_sync[2:1];
  assign sync_lane_fix = strap_sync[3];
  assign sync_clk = strap_sync[4];

  // load on the first edge after release; later strap moves are ignored
  always @* begin
    nxt_cap_state = cap_state_ff;
    load_straps = 1'h0;
    case (cap_state_ff)
      CAP_ARMED: begin
        nxt_cap_state = CAP_HOLD;
        load_straps = 1'h1; // R01
      end
      CAP_HOLD: begin
        nxt_cap_state = CAP_HOLD; // R01
      end
      default: begin
        nxt_cap_state = CAP_HOLD;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      cap_state_ff <= CAP_ARMED;
    end else begin
      cap_state_ff <= nxt_cap_state;
    end
  end

  // one next value and one flop per field keeps each default beside its field
  always @* begin
    nxt_little_endian = little_endian_select;
    if (load_straps) begin
      nxt_little_endian = sync_endian; // R03
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      little_endian_select <= `STRAP_DEFAULT_ENDIAN;
    end else begin
      little_endian_select <= nxt_little_endian;
    end
  end

  always @* begin
    nxt_boot_mode = boot_mode;
    if (load_straps) begin
      nxt_boot_mode = sync_boot;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      boot_mode <= `STRAP_DEFAULT_BOOT;
    end else begin
      boot_mode <= nxt_boot_mode;
    end
  end

  always @* begin
    nxt_host_boot = host_boot;
    if (load_straps) begin
      nxt_host_boot = is_host_code(sync_boot); // R04
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      host_boot <= `STRAP_DEFAULT_HOST;
    end else begin
      host_boot <= nxt_host_boot;
    end
  end

  always @* begin
    nxt_space_one_width = space_one_width;
    if (load_straps) begin
      nxt_space_one_width = width_of(sync_boot); // R04 R05
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      space_one_width <= `STRAP_DEFAULT_WIDTH;
    end else begin
      space_one_width <= nxt_space_one_width;
    end
  end

  always @* begin
    nxt_lane_fix = big_endian_lane_fix;
    if (load_straps) begin
      nxt_lane_fix = sync_lane_fix; // R08 R09
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      big_endian_lane_fix <= `STRAP_DEFAULT_LANE;
    end else begin
      big_endian_lane_fix <= nxt_lane_fix;
    end
  end

  always @* begin
    nxt_clock_times_four = clock_times_four;
    if (load_straps) begin
      nxt_clock_times_four = sync_clk; // R06
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      clock_times_four <= `STRAP_DEFAULT_CLK;
    end else begin
      clock_times_four <= nxt_clock_times_four;
    end
  end

  // reserved clock source level is only flagged, nothing relies on it
  always @* begin
    nxt_clock_strap_reserved = clock_strap_reserved;
    if (load_straps) begin
      nxt_clock_strap_reserved = !sync_clk;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      clock_strap_reserved <= `STRAP_DEFAULT_RESERVED;
    end else begin
      clock_strap_reserved <= nxt_clock_strap_reserved;
    end
  end

  always @* begin
    nxt_config_valid = config_valid;
    if (load_straps) begin
      nxt_config_valid = 1'h1; // R01
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      config_valid <= `CONFIG_VALID_RESET;
    end else begin
      config_valid <= nxt_config_valid;
    end
  end

  lane_steer u_lane (
    .little_endian_select(little_endian_select),
    .big_endian_lane_fix(big_endian_lane_fix),
    .narrow_on_high_lane(narrow_on_high_lane)
  );

  // write takes effect on the next edge; only the clock source bit is kept
  always @* begin
    nxt_cfg = cfg_ff;
    if (wr_stb && hits_config(addr)) begin
      nxt_cfg = wdata[`EXT_CLK_SEL_BIT]; // R11 R12
    end
  end

  // read data stand for one cycle after the strobe, zero otherwise
  always @* begin
    nxt_rdata = `DEVICE_CONFIG_RESET;
    if (rd_stb && hits_config(addr)) begin
      nxt_rdata = config_word(cfg_ff); // R11
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      cfg_ff <= `EXT_CLK_SEL_RESET; // R14
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= `DEVICE_CONFIG_RESET; // R14
    end else begin
      rdata <= nxt_rdata;
    end
  end

  // the memory clock choice leaves straight from its flop
  always @* begin
    ext_mem_clk_source_sel = cfg_ff; // R12
  end
endmodule // reset_strap_config
`default_nettype wire

/* verilog/strap_cfg_regs.vh */
// constants for the reset strap configuration loader
// assumes straps come from board pulls and reach the block asynchronously
//
// Summary of operation
// R01 - boot mode and strap choices latch at reset release, held until next reset
// R02 - board holds every strap steady through reset until its release
// R03 - endian strap 0 selects big endian, 1 little endian (default)
// R04 - boot code 00: space one 32-bit, boot via host port or emulation
// R05 - codes 01/10/11: async rom boot, space one 8/16/32-bit; 01 default
// R06 - original clock variant: clock strap 0 runs x1, 1 runs x4 (default)
// R07 - configurable clock variant: board keeps clock strap at 1; 0 reserved
// R08 - lane fix active: narrow external data always on lane bits 7 to 0
// R09 - lane fix at 1: narrow data on bits 31:24 big endian, 7:0 little
// R10 - board drives only free host data pins during reset, never opposes pulls
// R11 - software changes configuration after reset via register at fixed address
// R12 - register bit 4 selects memory clock: 0 third system clock, 1 pin
// R13 - software writes zeros to register bits 31:5 and 3:0
// R14 - configuration register reads all zeros after reset
`ifndef STRAP_CFG_REGS_VH
`define STRAP_CFG_REGS_VH
`define DEVICE_CONFIG_ADDR 32'h019C0200
`define DEVICE_CONFIG_RESET 32'h00000000
`define EXT_CLK_SEL_BIT 4
`define BOOT_HOST 2'h0
`define BOOT_ROM8 2'h1
`define BOOT_ROM16 2'h2
`define BOOT_ROM32 2'h3
`define WIDTH_8 2'h0
`define WIDTH_16 2'h1
`define WIDTH_32 2'h2
`define STRAP_DEFAULT_ENDIAN 1'h1
`define STRAP_DEFAULT_BOOT 2'h1
`define STRAP_DEFAULT_HOST 1'h0
`define STRAP_DEFAULT_WIDTH 2'h0
`define STRAP_DEFAULT_CLK 1'h1
`define STRAP_DEFAULT_RESERVED 1'h0
`define STRAP_DEFAULT_LANE 1'h1
`define CONFIG_VALID_RESET 1'h0
`define EXT_CLK_SEL_RESET 1'h0
`endif

/* verilog/strap_sync.v */
// two-flop synchroniser for a bus of strap levels
// assumes inputs are asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module strap_sync #(
  parameter W = 5
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // levels
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  always @(posedge mclk) begin
    if (!rst_n) begin
      meta_ff <= {W{1'h0}};
      sync_ff <= {W{1'h0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end
  assign sync_out = sync_ff;
endmodule // strap_sync
`default_nettype wire

/* verilog/lane_steer.v */
// external data lane placement for narrow accesses
// assumes latched endian and lane fix straps
`timescale 1ns/100ps
`default_nettype none
module lane_steer (
  // configuration
  input wire little_endian_select,
  input wire big_endian_lane_fix,
  // result
  output wire narrow_on_high_lane
);
  // high lane only in big endian without the fix
  assign narrow_on_high_lane = !little_endian_select && big_endian_lane_fix; // R08 R09
endmodule // lane_steer
`default_nettype wire

/* verification/strap_board.sv */
// board pulls on the strap pins
// assumes pick moves only while rst_n is low
`timescale 1ns/100ps
`default_nettype none
module strap_board (
  input wire logic mclk, rst_n,
  input wire logic [4:0] pick,
  output logic endian_strap, narrow_lane_fix_strap, clock_source_strap,
  output logic [1:0] boot_select_straps
);
  logic [4:0] lv = 5'h17;
  assign {endian_strap, boot_select_straps, narrow_lane_fix_strap, clock_source_strap} = lv;
  // levels only move in reset, so they are steady at release
  always @(posedge mclk) if (!rst_n) lv <= pick;
endmodule // strap_board
`default_nettype wire

/* verification/strap_cfg_asserts.sv */
// checker on the strap loader ports
// assumes one clock and rst_n sync active low
`timescale 1ns/100ps
`default_nettype none
module strap_cfg_asserts (
  input wire logic mclk, rst_n, wr_stb, rd_stb, host_boot, ext_mem_clk_source_sel, narrow_on_high_lane,
  input wire logic little_endian_select, big_endian_lane_fix, clock_times_four, clock_strap_reserved, config_valid,
  input wire logic [31:0] addr, wdata, rdata,
  input wire logic [1:0] boot_mode, space_one_width
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire hit = addr == 32'h019C0200;
  a_cfg_hold: assert property (config_valid && $past(config_valid) |->
    $stable({little_endian_select, boot_mode, big_endian_lane_fix, clock_times_four})) else $error("moved");
  a_host_code: assert property (host_boot == (boot_mode == 2'h0)) else $error("host");
  a_width_code: assert property (
    space_one_width == (boot_mode == 2'h0 ? 2'h2 : boot_mode - 2'h1)) else $error("width");
  a_lane_place: assert property (
    narrow_on_high_lane == (!little_endian_select && big_endian_lane_fix)) else $error("lane");
  a_clk_mode: assert property (clock_strap_reserved != clock_times_four) else $error("clk");
  a_sel_write: assert property (wr_stb && hit |=> ext_mem_clk_source_sel == $past(wdata[4])) else $error("sel");
  a_rd_back: assert property (
    rd_stb && hit |=> rdata == {27'h0, $past(ext_mem_clk_source_sel), 4'h0}) else $error("read");
  a_rd_idle: assert property (!(rd_stb && hit) |=> rdata == 32'h0) else $error("idle");
endmodule // strap_cfg_asserts
bind reset_strap_config strap_cfg_asserts strap_cfg_asserts_i (.*);
`default_nettype wire

/* verification/reset_strap_config_tb.sv */
// bench: strap rows, then register access
// assumes board model on the straps, checker bound
`timescale 1ns/100ps
`default_nettype none
module reset_strap_config_tb;
  logic mclk = 1'h0, rst_n = 1'h0, wr_stb = 1'h0, rd_stb = 1'h0, host_boot, config_valid, ext_mem_clk_source_sel;
  logic endian_strap, narrow_lane_fix_strap, clock_source_strap, little_endian_select, narrow_on_high_lane;
  logic big_endian_lane_fix, clock_times_four, clock_strap_reserved;
  logic [1:0] boot_select_straps, boot_mode, space_one_width;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
  logic [4:0] pick = 5'h17;
  // row: strap pick beside the expected latched outputs
  logic [14:0] rows [4] = '{15'h5E8C, 15'h086B, 15'h2514, 15'h77A4};
  wire [9:0] cfg = {little_endian_select, boot_mode, host_boot, space_one_width, big_endian_lane_fix,
    clock_times_four, clock_strap_reserved, narrow_on_high_lane};
  int failures = 0, cmp_count = 0;
  localparam logic [31:0] CFG = 32'h019C0200;
  reset_strap_config reset_strap_config_i (.*);
  strap_board strap_board_i (.*);
  initial forever #4 mclk = ~mclk;
  task chk(input string n, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one bus cycle; on a read d is the expected data
  task bus(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    {wr_stb, rd_stb, addr, wdata} <= {w, !w, a, d};
    @(posedge mclk);
    {wr_stb, rd_stb} <= 2'h0;
    #1;
    if (!w) chk("rdata", rdata, d);
  endtask
  task go(input logic [4:0] p);
    @(posedge mclk);
    {rst_n, pick} <= {1'h0, p};
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    #1;
    chk("reset", {22'h0, cfg}, 32'h28C);
    chk("held", {31'h0, config_valid}, 32'h0);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task complete_run;
    $display("compared %0d, bad %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    foreach (rows[i]) begin
      go(rows[i][14:10]);
      chk("config", {22'h0, cfg}, {22'h0, rows[i][9:0]});
      chk("valid", {31'h0, config_valid}, 32'h1);
      $display("row %0d done", i);
    end
    bus(1'h0, CFG, 32'h0);
    bus(1'h1, CFG, 32'h10);
    chk("sel", {31'h0, ext_mem_clk_source_sel}, 32'h1);
    bus(1'h0, CFG, 32'h10);
    bus(1'h1, CFG + 32'h4, 32'h0);
    bus(1'h0, CFG + 32'h4, 32'h0);
    chk("sel", {31'h0, ext_mem_clk_source_sel}, 32'h1);
    go(5'h17);
    chk("sel", {31'h0, ext_mem_clk_source_sel}, 32'h0);
    bus(1'h0, CFG, 32'h0);
    $display("register test done");
    complete_run();
  end
endmodule // reset_strap_config_tb
`default_nettype wire
